/* hrp_port.sv */
// hrp_port.sv: host direct I/O register port of the ring adapter.
// assumes host pins are asynchronous and held stable from chip select
// to its release; adapter-side inputs are synchronous to mclk.
`include "hrp_consts.svh"
module hrp_port
  import hrp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        host_cs_n,
  input  wire logic        host_wr_n,
  input  wire logic        interface_mode,
  input  wire logic        bus_width_select,
  input  wire logic        reg_select_hi,
  input  wire logic        reg_select_mid,
  input  wire logic        reg_select_lo,
  input  wire logic        byte_select_or_bus_error,
  input  wire logic        byte_high_enable_n,
  input  wire logic        upper_data_strobe_n,
  input  wire logic        lower_data_strobe_n,
  input  wire logic [15:0] host_din,
  output logic      [15:0] host_dout,
  output logic             host_dout_oe,
  input  wire logic [15:0] adp_rdata,
  input  wire logic [7:0]  adp_status,
  input  wire logic        adp_ddir,
  input  wire logic        adp_hold_req,
  input  wire logic        boot_strap,
  input  wire logic [1:0]  list_len_sel,
  output logic      [15:0] adapter_control,
  output logic      [15:0] adapter_address,
  output logic      [7:0]  command_register,
  output logic             command_strobe,
  output logic      [15:0] mem_wdata,
  output logic      [1:0]  mem_lanes,
  output logic             mem_wr_strobe,
  output logic             mem_rd_strobe,
  output logic      [4:0]  list_entry_bytes,
  output logic      [4:0]  status_block_bytes
);

  // ------------------------------------------------------------
  // pin synchronisation
  // ------------------------------------------------------------
  logic [26:0] pin_raw;   // all host pins in one bundle
  logic [26:0] pin_q;     // filtered pins
  assign pin_raw = {host_cs_n, host_wr_n, interface_mode, bus_width_select,
                    reg_select_hi, reg_select_mid, reg_select_lo,
                    byte_select_or_bus_error, byte_high_enable_n,
                    upper_data_strobe_n, lower_data_strobe_n, host_din};

  hrp_sync #(.W(27)) u_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      (pin_raw),
    .q      (pin_q)
  );

  logic        f_cs_n;    // filtered chip select
  logic        f_wr_n;    // filtered write strobe
  logic        f_mode;    // high: low-byte-first host
  logic        f_s8;      // high with f_mode high: 8-bit host bus
  logic [2:0]  f_code;    // register select code
  logic        f_bse;     // byte select / address bit zero
  logic        f_bhe_n;   // byte high enable
  logic        f_uds_n;   // upper data strobe
  logic        f_lds_n;   // lower data strobe
  logic [15:0] f_din;     // host write data
  assign {f_cs_n, f_wr_n, f_mode, f_s8, f_code, f_bse, f_bhe_n,
          f_uds_n, f_lds_n, f_din} = pin_q;

  // ------------------------------------------------------------
  // select and lane decode
  // ------------------------------------------------------------
  logic     [15:0] acl_q;     // adapter control view
  logic            pdma_map;  // pseudo-DMA remap active for low codes
  hrp_rid_t        dec_rid;   // decoded target
  logic            mode8;     // 8-bit host bus
  logic            intel16;   // 16-bit low-byte-first bus
  logic            dec_hi;    // high lane chosen
  logic            dec_lo;    // low lane chosen

  assign pdma_map = acl_q[`HRP_ACL_PSEUDO_DMA_ENABLE] & ~f_code[2];
  assign dec_rid  =
      (pdma_map && f_code == `HRP_SEL_DATA)     ? RID_PDATA    :
      (pdma_map && f_code == `HRP_SEL_DATA_INC) ? RID_DMA_LENGTH   :
      (pdma_map && f_code == `HRP_SEL_ADDR)     ? RID_PADDR    :
      (pdma_map && f_code == `HRP_SEL_CMDSTS)   ? RID_PADX     :
      (f_code == `HRP_SEL_DATA)                 ? RID_DATA     :
      (f_code == `HRP_SEL_DATA_INC)             ? RID_DATA_INC :
      (f_code == `HRP_SEL_CMDSTS)               ? RID_CMDSTS   :
      (f_code == `HRP_SEL_ACL)                  ? RID_ACL      :
      (f_code == `HRP_SEL_ADDR_EXT)             ? RID_ADDR_EXT :
      (f_code == `HRP_SEL_DMA_LENGTH)               ? RID_DMA_LENGTH   :
      RID_ADDR;                               // address and its alias
  assign mode8   = f_mode & f_s8;
  assign intel16 = f_mode & ~f_s8;
  // 8-bit: odd code bit picks high byte, high enable ignored
  assign dec_hi = mode8   ? f_bse :
                  intel16 ? ~f_bhe_n :
                  ~f_uds_n;
  assign dec_lo = mode8   ? ~f_bse :
                  intel16 ? ~f_bse :
                  ~f_lds_n;

  // ------------------------------------------------------------
  // access sequencing: capture at start, execute one cycle later
  // ------------------------------------------------------------
  logic     act_ff;     // access seen active last cycle
  logic     exec_ff;    // execute pulse
  logic     wr_ff;      // captured direction
  logic     m8_ff;      // captured bus width
  logic     hi_ff;      // captured high lane
  logic     lo_ff;      // captured low lane
  hrp_rid_t rid_ff;     // captured target
  logic     start;      // first active cycle

  assign start = ~f_cs_n & ~act_ff;

  // selection frozen for the whole access, pins may wander after
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      act_ff  <= 1'b0;
      exec_ff <= 1'b0;
      wr_ff   <= 1'b0;
      m8_ff   <= 1'b0;
      hi_ff   <= 1'b0;
      lo_ff   <= 1'b0;
      rid_ff  <= RID_DATA;
    end else begin
      act_ff  <= ~f_cs_n;
      exec_ff <= start;
      if (start) begin
        wr_ff  <= ~f_wr_n;
        m8_ff  <= mode8;
        hi_ff  <= dec_hi & (dec_rid != RID_PDATA);
        lo_ff  <= dec_lo;
        rid_ff <= dec_rid;
      end
    end
  end

  // ------------------------------------------------------------
  // write data and strobes per register
  // ------------------------------------------------------------
  logic [15:0] wdata;   // byte steered to its lane on 8-bit hosts
  logic        wr_hi;   // high byte written this cycle
  logic        wr_lo;   // low byte written this cycle
  logic        touch_hi; // access reached the high (odd) byte
  assign wdata = m8_ff ? {f_din[7:0], f_din[7:0]} : f_din;
  assign wr_hi = exec_ff & wr_ff & hi_ff;
  assign wr_lo = exec_ff & wr_ff & lo_ff;
  assign touch_hi = exec_ff & hi_ff;

  // odd byte comes last, so the step follows the high-byte access
  logic inc_addr;  // auto-increment request
  assign inc_addr = touch_hi & (rid_ff == RID_DATA_INC);

  logic [15:0] addr_q;   // adapter address
  logic [15:0] adx_q;    // extended address
  logic [15:0] dlen_q;   // dma length
  logic [15:0] paddr_q;  // pseudo-DMA address
  logic [15:0] padx_q;   // pseudo-DMA extended address

  hrp_reg16 u_addr (
    .mclk (mclk), .arst_n (arst_n),
    .wr_hi (wr_hi & (rid_ff == RID_ADDR)), .wr_lo (wr_lo & (rid_ff == RID_ADDR)),
    .inc (inc_addr), .wdata (wdata), .q (addr_q)
  );
  hrp_reg16 u_adx (
    .mclk (mclk), .arst_n (arst_n),
    .wr_hi (wr_hi & (rid_ff == RID_ADDR_EXT)),
    .wr_lo (wr_lo & (rid_ff == RID_ADDR_EXT)),
    .inc (1'b0), .wdata (wdata), .q (adx_q)
  );
  hrp_reg16 u_dlen (
    .mclk (mclk), .arst_n (arst_n),
    .wr_hi (wr_hi & (rid_ff == RID_DMA_LENGTH)), .wr_lo (wr_lo & (rid_ff == RID_DMA_LENGTH)),
    .inc (1'b0), .wdata (wdata), .q (dlen_q)
  );
  hrp_reg16 u_paddr (
    .mclk (mclk), .arst_n (arst_n),
    .wr_hi (wr_hi & (rid_ff == RID_PADDR)), .wr_lo (wr_lo & (rid_ff == RID_PADDR)),
    .inc (1'b0), .wdata (wdata), .q (paddr_q)
  );
  hrp_reg16 u_padx (
    .mclk (mclk), .arst_n (arst_n),
    .wr_hi (wr_hi & (rid_ff == RID_PADX)), .wr_lo (wr_lo & (rid_ff == RID_PADX)),
    .inc (1'b0), .wdata (wdata), .q (padx_q)
  );

  // ------------------------------------------------------------
  // adapter control register
  // ------------------------------------------------------------
  logic [15:0] acl_ff;      // stored control bits
  logic [15:0] nxt_acl;     // next control bits
  logic        strap_done_ff; // boot strap captured after reset
  logic        hrq_d_ff;    // hold request last cycle
  logic        acl_wr_hi;   // high byte written
  logic        acl_wr_lo;   // low byte written
  logic        ares;        // adapter reset currently set
  logic        ares_rise;   // adapter reset written 0 to 1

  assign acl_wr_hi = wr_hi & (rid_ff == RID_ACL);
  assign acl_wr_lo = wr_lo & (rid_ff == RID_ACL);
  assign ares      = acl_ff[`HRP_ACL_ADAPTER_SOFT_RESET];
  assign ares_rise = acl_wr_hi & ~ares & wdata[`HRP_ACL_ADAPTER_SOFT_RESET];

  always_comb begin
    nxt_acl = acl_ff;
    if (acl_wr_lo) begin
      // hold ack only with reset low, pseudo-DMA on and request up
      if (!ares && acl_ff[`HRP_ACL_PSEUDO_DMA_ENABLE] && adp_hold_req) begin
        nxt_acl[`HRP_ACL_SOFTWARE_HOLD_ACK] = wdata[`HRP_ACL_SOFTWARE_HOLD_ACK];
      end else if (!wdata[`HRP_ACL_SOFTWARE_HOLD_ACK]) begin
        nxt_acl[`HRP_ACL_SOFTWARE_HOLD_ACK] = 1'b0;
      end
      if (!ares || !wdata[`HRP_ACL_PSEUDO_DMA_ENABLE]) begin
        nxt_acl[`HRP_ACL_PSEUDO_DMA_ENABLE] = wdata[`HRP_ACL_PSEUDO_DMA_ENABLE];
      end
    end
    if (acl_wr_hi) begin
      nxt_acl[`HRP_ACL_ADAPTER_SOFT_RESET] = wdata[`HRP_ACL_ADAPTER_SOFT_RESET];
      nxt_acl[`HRP_ACL_PEN]    = wdata[`HRP_ACL_PEN];
      if (!ares) begin
        nxt_acl[`HRP_ACL_INTEN] = wdata[`HRP_ACL_INTEN];
      end
      // halt and boot freely writable only under adapter reset
      if (ares) begin
        nxt_acl[`HRP_ACL_PROCESSOR_HALT] = wdata[`HRP_ACL_PROCESSOR_HALT];
        nxt_acl[`HRP_ACL_BOOT]   = wdata[`HRP_ACL_BOOT];
      end else if (!wdata[`HRP_ACL_PROCESSOR_HALT]) begin
        nxt_acl[`HRP_ACL_PROCESSOR_HALT] = 1'b0;
      end
    end
    // reset entry reloads halt and boot from the strap
    if (ares_rise || !strap_done_ff) begin
      nxt_acl[`HRP_ACL_PROCESSOR_HALT] = boot_strap;
      nxt_acl[`HRP_ACL_BOOT]   = boot_strap;
    end
    // end of pseudo-DMA drops hold ack
    if (hrq_d_ff && !adp_hold_req) begin
      nxt_acl[`HRP_ACL_SOFTWARE_HOLD_ACK] = 1'b0;
    end
    nxt_acl[3:0]                = 4'h0;
    nxt_acl[`HRP_ACL_DDIR]      = 1'b0;
    nxt_acl[`HRP_ACL_HRQ]       = 1'b0;
    nxt_acl[`HRP_ACL_RSVD11]    = 1'b0;
    nxt_acl[15:14]              = 2'h0;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      acl_ff        <= 16'h0000;
      acl_ff[`HRP_ACL_INTEN] <= `HRP_ACL_INTEN_RST;
      strap_done_ff <= 1'b0;
      hrq_d_ff      <= 1'b0;
    end else begin
      acl_ff        <= nxt_acl;
      strap_done_ff <= 1'b1;
      hrq_d_ff      <= adp_hold_req;
    end
  end

  // live direction and request bits merged into the view
  assign acl_q = acl_ff | ({15'h0000, adp_ddir} << `HRP_ACL_DDIR)
                        | ({15'h0000, adp_hold_req} << `HRP_ACL_HRQ);

  // ------------------------------------------------------------
  // command, data port, pseudo-DMA data and read-back
  // ------------------------------------------------------------
  logic [7:0]  cmd_ff;     // command byte
  logic        cmd_stb_ff; // command written
  logic [7:0]  pdat_ff;    // pseudo-DMA data byte
  logic [15:0] mwd_ff;     // adapter memory write data
  logic [1:0]  mln_ff;     // adapter memory lanes
  logic        mwr_ff;     // memory write strobe
  logic        mrd_ff;     // memory read strobe
  logic [15:0] dout_ff;    // host read data
  logic [4:0]  lst_ff;     // list entry length
  logic [15:0] rd_word;    // selected register word
  logic        is_data;    // data port targeted

  assign is_data = (rid_ff == RID_DATA) | (rid_ff == RID_DATA_INC);
  assign rd_word = is_data                  ? adp_rdata :
                   (rid_ff == RID_CMDSTS)   ? {cmd_ff, adp_status} :
                   (rid_ff == RID_ACL)      ? acl_q :
                   (rid_ff == RID_ADDR)     ? addr_q :
                   (rid_ff == RID_ADDR_EXT) ? adx_q :
                   (rid_ff == RID_DMA_LENGTH)   ? dlen_q :
                   (rid_ff == RID_PADDR)    ? paddr_q :
                   (rid_ff == RID_PADX)     ? padx_q :
                   {8'h00, pdat_ff};

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_ff     <= 8'h00;
      cmd_stb_ff <= 1'b0;
      pdat_ff    <= 8'h00;
      mwd_ff     <= 16'h0000;
      mln_ff     <= 2'h0;
      mwr_ff     <= 1'b0;
      mrd_ff     <= 1'b0;
      dout_ff    <= 16'h0000;
      lst_ff     <= `HRP_LIST_SHORT;
    end else begin
      cmd_stb_ff <= wr_hi & (rid_ff == RID_CMDSTS);
      mwr_ff     <= exec_ff & wr_ff & is_data;
      mrd_ff     <= exec_ff & ~wr_ff & is_data;
      if (wr_hi && rid_ff == RID_CMDSTS) begin
        cmd_ff <= wdata[15:8];
      end
      if (wr_lo && rid_ff == RID_PDATA) begin
        pdat_ff <= wdata[7:0];
      end
      if (exec_ff && is_data) begin
        mwd_ff <= wdata;
        mln_ff <= {hi_ff, lo_ff};
      end
      if (exec_ff && !wr_ff) begin
        // 8-bit hosts see the chosen byte on the low lines
        dout_ff <= (m8_ff && hi_ff) ? {8'h00, rd_word[15:8]} :
                   {hi_ff ? rd_word[15:8] : 8'h00,
                    lo_ff ? rd_word[7:0]  : 8'h00};
      end
      lst_ff <= (list_len_sel == 2'h2) ? `HRP_LIST_LONG :
                (list_len_sel == 2'h1) ? `HRP_LIST_MID : `HRP_LIST_SHORT;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign host_dout          = dout_ff;
  assign host_dout_oe       = act_ff & ~exec_ff & ~f_cs_n & ~wr_ff & ~start;
  assign adapter_control    = acl_q;
  assign adapter_address    = addr_q;
  assign command_register   = cmd_ff;
  assign command_strobe     = cmd_stb_ff;
  assign mem_wdata          = mwd_ff;
  assign mem_lanes          = mln_ff;
  assign mem_wr_strobe      = mwr_ff;
  assign mem_rd_strobe      = mrd_ff;
  assign list_entry_bytes   = lst_ff;
  assign status_block_bytes = `HRP_SSB_BYTES;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_low_bits_zero: assert property (@(posedge mclk) disable iff (!arst_n)
    acl_q[3:0] == 4'h0) else $error("control low bits not zero");
  a_rsvd_zero: assert property (@(posedge mclk) disable iff (!arst_n)
    !acl_q[`HRP_ACL_RSVD11]) else $error("reserved bit 11 set");
  a_exec_follows: assert property (@(posedge mclk) disable iff (!arst_n)
    start |=> exec_ff ##1 $stable(rid_ff)) else $error("exec not after start");
  a_word_both: assert property (@(posedge mclk) disable iff (!arst_n)
    start && intel16 && !f_bhe_n && !f_bse && dec_rid != RID_PDATA
    |=> hi_ff && lo_ff) else $error("word access lost a lane");
  a_strobe_lane: assert property (@(posedge mclk) disable iff (!arst_n)
    start && !f_mode && f_uds_n && !f_lds_n |=> !hi_ff && lo_ff)
    else $error("strobe lane wrong");
  a_pdma_byte: assert property (@(posedge mclk) disable iff (!arst_n)
    exec_ff && rid_ff == RID_PDATA |-> !hi_ff) else $error("pseudo data high lane");
  a_pdma_map: assert property (@(posedge mclk) disable iff (!arst_n)
    start && acl_q[`HRP_ACL_PSEUDO_DMA_ENABLE] && f_code == `HRP_SEL_ADDR
    |=> rid_ff == RID_PADDR) else $error("pseudo remap wrong");
  a_autoinc: assert property (@(posedge mclk) disable iff (!arst_n)
    inc_addr && !(wr_hi || wr_lo) |=> addr_q == $past(addr_q) + `HRP_ADDR_STEP)
    else $error("address not stepped");
  a_byte8_lane: assert property (@(posedge mclk) disable iff (!arst_n)
    start && mode8 && f_bse |=> hi_ff && !lo_ff) else $error("8-bit lane wrong");

endmodule

/* hrp_consts.svh */
// hrp_consts.svh: offsets, field positions, reset values and sizes of the
// host register port. Definitions only; included by the port, the register and the bench.
`ifndef HRP_CONSTS_SVH
`define HRP_CONSTS_SVH

// ------------------------------------------------------------
// register select codes (three select pins)
// ------------------------------------------------------------
`define HRP_SEL_DATA      3'h0
`define HRP_SEL_DATA_INC  3'h1
`define HRP_SEL_ADDR      3'h2
`define HRP_SEL_CMDSTS    3'h3
`define HRP_SEL_ACL       3'h4
`define HRP_SEL_ADDR_ALS  3'h5
`define HRP_SEL_ADDR_EXT  3'h6
`define HRP_SEL_DMA_LENGTH    3'h7

// ------------------------------------------------------------
// adapter_control field positions
// ------------------------------------------------------------
`define HRP_ACL_SOFTWARE_HOLD_ACK    4
`define HRP_ACL_DDIR      5
`define HRP_ACL_HRQ       6
`define HRP_ACL_PSEUDO_DMA_ENABLE   7
`define HRP_ACL_ADAPTER_SOFT_RESET    8
`define HRP_ACL_PROCESSOR_HALT    9
`define HRP_ACL_BOOT      10
`define HRP_ACL_RSVD11    11
`define HRP_ACL_INTEN     12
`define HRP_ACL_PEN       13

// ------------------------------------------------------------
// reset values, steps and memory block sizes
// ------------------------------------------------------------
`define HRP_ACL_INTEN_RST 1'h1
`define HRP_REG_RST       16'h0000
`define HRP_ADDR_STEP     16'h0002
`define HRP_SCB_BYTES     5'h06
`define HRP_SSB_BYTES     5'h08
`define HRP_PID_BYTES     5'h12
`define HRP_LIST_SHORT    5'h0E
`define HRP_LIST_MID      5'h14
`define HRP_LIST_LONG     5'h1A
`define HRP_MIN_LISTS     2'h3

`endif

/* hrp_pkg.sv */
// hrp_pkg.sv: types shared by the host register port files.
// assumes hrp_consts.svh is on the include path.
package hrp_pkg;

  // ------------------------------------------------------------
  // logical register targets after select decode
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    RID_DATA, RID_DATA_INC, RID_ADDR, RID_CMDSTS, RID_ACL,
    RID_ADDR_EXT, RID_DMA_LENGTH, RID_PDATA, RID_PADDR, RID_PADX
  } hrp_rid_t;

endpackage

/* hrp_sync.sv */
// hrp_sync.sv: three-stage pin synchroniser with agreement filter.
// assumes inputs are asynchronous to mclk; output updates only when the
// second and third stages agree.
module hrp_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_ff;  // first stage, read only by s2
  logic [W-1:0] s2_ff;  // second stage
  logic [W-1:0] s3_ff;  // third stage
  logic [W-1:0] q_ff;   // filtered value

  // ------------------------------------------------------------
  // shift chain; a bit changes once stages two and three agree
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= '1;
      s2_ff <= '1;
      s3_ff <= '1;
      q_ff  <= '1;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff  <= (s2_ff & s3_ff) | (q_ff & (s2_ff ^ s3_ff));
    end
  end

  assign q = q_ff;

endmodule

/* hrp_reg16.sv */
// hrp_reg16.sv: 16-bit register with independent byte writes and an
// optional word-address increment.
// assumes write and increment never collide (the register gives writes priority).
`include "hrp_consts.svh"
module hrp_reg16 (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        wr_hi,
  input  wire logic        wr_lo,
  input  wire logic        inc,
  input  wire logic [15:0] wdata,
  output logic      [15:0] q
);

  logic [15:0] val_ff;      // stored value
  logic [15:0] nxt_val;     // next value

  // byte lanes merged, increment only without a write
  assign nxt_val = (wr_hi | wr_lo) ?
                   {wr_hi ? wdata[15:8] : val_ff[15:8],
                    wr_lo ? wdata[7:0]  : val_ff[7:0]} :
                   (inc ? val_ff + `HRP_ADDR_STEP : val_ff);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      val_ff <= `HRP_REG_RST;
    end else begin
      val_ff <= nxt_val;
    end
  end

  assign q = val_ff;

endmodule

/* hrp_host.sv */
// hrp_host.sv: behavioural host processor on the register port pins.
// assumes a free-running mclk; the caller waits for each access to end.
module hrp_host (
  input  wire logic        mclk,
  input  wire logic        oe,
  input  wire logic [15:0] dout,
  output logic             cs_n,
  output logic             wr_n,
  output logic      [3:0]  sel,
  output logic      [2:0]  lane_n,
  output logic      [15:0] din
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // idle pins at time zero
  // ----------------------------------------
  initial begin
    {cs_n, wr_n, sel, lane_n, din} = {2'h3, 4'h0, 3'h7, 16'h0000};
  end
  // host memory blocks stay outside this pin model: six-byte command block
  // 18-byte id area three lists each way parameter block kept
  // one access; callers order even byte before odd
  task automatic acc(input logic w, input logic [3:0] s, input logic [2:0] ln,
                     input logic [15:0] d, output logic [15:0] q, output logic ok);
    @(posedge mclk);
    #1;
    {cs_n, wr_n, sel, lane_n, din} = {1'b0, ~w, s, ln, d};
    ok = w;
    // reads: drive enable must come within a bounded wait
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge mclk);
      #1;
      ok = (oe === 1'b1);
    end
    // select held well past the eight-edge minimum
    repeat (10) @(posedge mclk);
    #1;
    q = dout;
    // released data shows the inverse, never a stale copy
    {cs_n, din} = {1'b1, ~d};
    repeat (6) @(posedge mclk);
    // return off the edge so callers change pins away from it
    #1;
  endtask
endmodule

/* tb_top.sv */
// tb_top.sv: self-checking bench for the host register port.
// assumes hrp_host.sv and the design files are compiled before it.
`include "hrp_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, arst_n, host_cs_n, host_wr_n, interface_mode, bus_width_select, ok;
  logic reg_select_hi, reg_select_mid, reg_select_lo, byte_select_or_bus_error;
  logic byte_high_enable_n, upper_data_strobe_n, lower_data_strobe_n, host_dout_oe;
  logic adp_ddir, adp_hold_req, boot_strap, command_strobe, mem_wr_strobe, mem_rd_strobe;
  logic [15:0] host_din, host_dout, adp_rdata, adapter_control, adapter_address, mem_wdata, q;
  logic [7:0] adp_status, command_register;
  logic [4:0] list_entry_bytes, status_block_bytes;
  logic [1:0] list_len_sel, mem_lanes;
  int miscompares, n_compared;
  int n_cmd, n_mem;
  // one-cycle strobes counted mid-cycle, away from the launching edge
  always @(negedge mclk) begin
    n_cmd += command_strobe;
    n_mem += mem_wr_strobe + mem_rd_strobe;
  end
  hrp_port hrp_port_i (.mclk(mclk), .arst_n(arst_n), .host_cs_n(host_cs_n),
    .host_wr_n(host_wr_n), .interface_mode(interface_mode),
    .bus_width_select(bus_width_select), .reg_select_hi(reg_select_hi),
    .reg_select_mid(reg_select_mid), .reg_select_lo(reg_select_lo),
    .byte_select_or_bus_error(byte_select_or_bus_error),
    .byte_high_enable_n(byte_high_enable_n), .upper_data_strobe_n(upper_data_strobe_n),
    .lower_data_strobe_n(lower_data_strobe_n), .host_din(host_din),
    .host_dout(host_dout), .host_dout_oe(host_dout_oe), .adp_rdata(adp_rdata),
    .adp_status(adp_status), .adp_ddir(adp_ddir), .adp_hold_req(adp_hold_req),
    .boot_strap(boot_strap), .list_len_sel(list_len_sel),
    .adapter_control(adapter_control), .adapter_address(adapter_address),
    .command_register(command_register), .command_strobe(command_strobe),
    .mem_wdata(mem_wdata), .mem_lanes(mem_lanes), .mem_wr_strobe(mem_wr_strobe),
    .mem_rd_strobe(mem_rd_strobe), .list_entry_bytes(list_entry_bytes),
    .status_block_bytes(status_block_bytes));
  hrp_host hrp_host_i (.mclk(mclk), .oe(host_dout_oe), .dout(host_dout), .cs_n(host_cs_n),
    .wr_n(host_wr_n), .sel({reg_select_hi, reg_select_mid, reg_select_lo,
    byte_select_or_bus_error}), .lane_n({byte_high_enable_n, upper_data_strobe_n,
    lower_data_strobe_n}), .din(host_din));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  always #50 mclk = ~mclk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // access through the host model; a lost answer ends the run
  task automatic rw(input logic w, input logic [3:0] s, input logic [2:0] ln,
                    input logic [15:0] d);
    hrp_host_i.acc(w, s, ln, d, q, ok);
    if (!ok) begin
      miscompares++;
      stop_test();
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_ctrl();
    rw(0, 4'h8, 3'h3, 16'h0000);
    chk(q, 16'h1020);
    chk(adapter_control, 16'h1020);
    rw(1, 4'h8, 3'h3, 16'h200F);
    rw(0, 4'h8, 3'h3, 16'h0000);
    chk(q, 16'h2020);
    chk(status_block_bytes, `HRP_SSB_BYTES);
  endtask
  task automatic t_lanes();
    rw(1, 4'h4, 3'h3, 16'hA5C3);
    chk(adapter_address, 16'hA5C3);
    rw(1, 4'h5, 3'h3, 16'h7E00);
    chk(adapter_address, 16'h7EC3);
    interface_mode = 0;
    rw(1, 4'hA, 3'h5, 16'h3C00);
    chk(adapter_address, 16'h3CC3);
    rw(1, 4'hA, 3'h6, 16'h0011);
    rw(0, 4'h4, 3'h4, 16'h0000);
    chk(q, 16'h3C11);
  endtask
  task automatic t_byte8();
    {interface_mode, bus_width_select, adp_status} = {2'h3, 8'h9A};
    rw(1, 4'h7, 3'h7, 16'h0055);
    chk(command_register, 8'h55);
    rw(0, 4'h6, 3'h7, 16'h0000);
    chk(q, 16'h009A);
    rw(0, 4'h4, 3'h7, 16'h0000);
    chk(q, 16'h0011);
    rw(0, 4'h5, 3'h7, 16'h0000);
    chk(q, 16'h003C);
    rw(0, 4'h3, 3'h7, 16'h0000);
    chk(adapter_address, 16'h3C13);
    rw(1, 4'h0, 3'h7, 16'h005A);
    chk({mem_lanes, 6'h00, mem_wdata[7:0]}, 16'h405A);
    chk(16'(n_cmd), 16'h0001);
    chk(16'(n_mem), 16'h0002);
  endtask
  task automatic t_pdma();
    {interface_mode, bus_width_select} = 2'h2;
    rw(1, 4'h8, 3'h6, 16'h0080);
    chk(adapter_control, 16'h20A0);
    rw(1, 4'h0, 3'h3, 16'hBEEF);
    rw(0, 4'h0, 3'h3, 16'h0000);
    chk(q, 16'h00EF);
    rw(1, 4'h4, 3'h3, 16'h1234);
    rw(0, 4'h4, 3'h3, 16'h0000);
    chk(q, 16'h1234);
    chk(adapter_address, 16'h3C13);
  endtask
  task automatic t_lists();
    for (int i = 0; i < 3; i++) begin
      list_len_sel = i[1:0];
      repeat (3) @(posedge mclk);
      #1;
      chk(list_entry_bytes, 5'h0E + 5'(6 * i));
    end
  endtask
  initial begin
    {mclk, arst_n, interface_mode, bus_width_select, adp_ddir, adp_hold_req} = 6'h0A;
    {boot_strap, adp_rdata, adp_status, list_len_sel} = 27'h0;
    repeat (20) @(posedge mclk);
    #1;
    arst_n = 1;
    t_ctrl();
    t_lanes();
    t_byte8();
    t_pdma();
    t_lists();
    stop_test();
  end
endmodule
